// >>> src/ess_sequencer.sv
`timescale 1ns/100ps

module ess_sequencer #(
    parameter int EE_AW = 10
) (
    // Clock and reset.
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite write address channel.
    input  wire logic [15:0]         s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // AXI4-Lite write data channel.
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read address channel.
    input  wire logic [15:0]         s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    // AXI4-Lite read data channel.
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Register-map read port, combinational read of map_addr.
    output logic [15:0]              map_addr,
    input  wire logic [7:0]          map_rdata,
    // EEPROM byte write port.
    output logic [EE_AW-1:0]         ee_addr,
    output logic [7:0]               ee_wdata,
    output logic                     ee_wr
);
    import ess_pkg::*;

    // Sequence slot of a bus address, or 4'hf when it is not a sequence byte.
    function automatic logic [3:0] seq_slot(input logic [15:0] addr);
        logic [13:0] idx;
        idx = addr[15:2];
        if (idx >= ESS_IDX_REFIN_INSTR && idx <= ESS_IDX_PROF23_LO)
            seq_slot = 4'(idx - ESS_IDX_REFIN_INSTR);
        else
            seq_slot = 4'hf;
    endfunction

    // Register state.
    logic [7:0]       seq_q [9];
    logic [EE_AW-1:0] ptr_q;
    logic             done_q;
    logic             bad_q;
    ess_state_t       state_q;
    logic [3:0]       idx_q;
    logic [7:0]       cnt_q;
    logic [7:0]       off_q;
    logic [15:0]      base_q;
    logic [7:0]       sum_q;
    logic [7:0]       cur;
    logic             busy;

    // Bus-side holding registers.
    logic [15:0]      awaddr_q;
    logic [31:0]      wdata_q;
    logic [3:0]       wstrb_q;
    logic             do_wr;
    logic [3:0]       wr_slot;
    logic [13:0]      wr_idx;
    logic             wr_lane0;
    logic             start_req;

    // Byte under the sequencer's cursor; the index is kept below nine wherever it is used.
    assign cur       = (idx_q < ESS_SEQ_LEN) ? seq_q[idx_q] : 8'h00;
    assign busy      = (state_q != ESS_IDLE);
    assign do_wr     = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_slot   = seq_slot(awaddr_q);
    assign wr_idx    = awaddr_q[15:2];
    assign wr_lane0  = wstrb_q[0];
    assign start_req = do_wr && wr_lane0 && (wr_idx == ESS_IDX_CTRL)
                       && wdata_q[ESS_CTRL_START_BIT] && !busy;

    // Write address and data are caught in either order; the response waits for both.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ESS_RESP_OKAY;
            awaddr_q      <= 16'h0000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr)
            begin
                s_axi_bvalid <= 1'b1;
                if (wr_slot != 4'hf || wr_idx == ESS_IDX_CTRL || wr_idx == ESS_IDX_STATUS
                    || wr_idx == ESS_IDX_POINTER)
                    s_axi_bresp <= ESS_RESP_OKAY;
                else
                    s_axi_bresp <= ESS_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read answers one cycle after the address is taken; unmapped reads give zero and an error.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= ESS_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= ESS_RESP_OKAY;
            if (seq_slot(s_axi_araddr) != 4'hf)
                s_axi_rdata <= {24'h00_0000, seq_q[seq_slot(s_axi_araddr)]};
            else if (s_axi_araddr[15:2] == ESS_IDX_CTRL)
                s_axi_rdata <= 32'h0000_0000;
            else if (s_axi_araddr[15:2] == ESS_IDX_STATUS)
                s_axi_rdata <= {29'h0000_0000, bad_q, done_q, busy};
            else if (s_axi_araddr[15:2] == ESS_IDX_POINTER)
                s_axi_rdata <= 32'(ptr_q);
            else
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= ESS_RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Sequence bytes; software writes are dropped while a save runs so the walk sees a stable list.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < 9; i++)
                seq_q[i] <= ESS_SEQ_RESET[i*8 +: 8];
        end
        else if (do_wr && wr_lane0 && wr_slot != 4'hf && !busy)
        begin
            seq_q[wr_slot] <= wdata_q[7:0];
        end
    end

    // Sticky done and bad flags; a hardware set in the clearing cycle wins.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            done_q <= 1'b0;
            bad_q  <= 1'b0;
        end
        else
        begin
            if (do_wr && wr_lane0 && wr_idx == ESS_IDX_STATUS && wdata_q[ESS_STAT_DONE_BIT])
                done_q <= 1'b0;
            if (do_wr && wr_lane0 && wr_idx == ESS_IDX_STATUS && wdata_q[ESS_STAT_BAD_BIT])
                bad_q <= 1'b0;
            if (state_q == ESS_FETCH && idx_q >= ESS_SEQ_LEN)
                done_q <= 1'b1;
            if (state_q == ESS_FETCH && idx_q < ESS_SEQ_LEN && cur != ESS_OP_IO_UPDATE
                && (cur[ESS_OP_KIND_BIT] || idx_q + 4'h2 >= ESS_SEQ_LEN))
                bad_q <= 1'b1;
        end
    end

    // EEPROM pointer: software sets the start location while idle, every stored byte advances it.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ptr_q <= EE_AW'(ESS_POINTER_RESET);
        else if (do_wr && wr_lane0 && wr_idx == ESS_IDX_POINTER && !busy)
            ptr_q <= wdata_q[EE_AW-1:0];
        else if (state_q == ESS_FETCH && idx_q < ESS_SEQ_LEN && cur == ESS_OP_IO_UPDATE)
            ptr_q <= ptr_q + 1'b1;
        else if (state_q == ESS_FETCH && idx_q + 4'h2 < ESS_SEQ_LEN && !cur[ESS_OP_KIND_BIT])
            ptr_q <= ptr_q + 1'b1;
        else if (state_q == ESS_ADDR_HI || state_q == ESS_ADDR_LO)
            ptr_q <= ptr_q + 1'b1;
        else if (state_q == ESS_WR || state_q == ESS_CSUM)
            ptr_q <= ptr_q + 1'b1;
    end

    // Walk of the sequence list; a byte of the list needs one cycle, a copied byte two.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= ESS_IDLE;
            idx_q   <= 4'h0;
            cnt_q   <= 8'h00;
            off_q   <= 8'h00;
            base_q  <= 16'h0000;
        end
        else
        begin
            case (state_q)
                ESS_IDLE:
                begin
                    idx_q <= 4'h0;
                    if (start_req)
                        state_q <= ESS_FETCH;
                end
                ESS_FETCH:
                begin
                    if (idx_q >= ESS_SEQ_LEN)
                        state_q <= ESS_IDLE;
                    else if (cur == ESS_OP_IO_UPDATE)
                        idx_q <= idx_q + 4'h1;
                    else if (!cur[ESS_OP_KIND_BIT] && idx_q + 4'h2 < ESS_SEQ_LEN)
                    begin
                        // A data instruction must have both address bytes still in the list.
                        cnt_q   <= cur;
                        idx_q   <= idx_q + 4'h1;
                        state_q <= ESS_ADDR_HI;
                    end
                    else
                        state_q <= ESS_IDLE;
                end
                ESS_ADDR_HI:
                begin
                    base_q[15:8] <= cur;
                    idx_q        <= idx_q + 4'h1;
                    state_q      <= ESS_ADDR_LO;
                end
                ESS_ADDR_LO:
                begin
                    base_q[7:0] <= cur;
                    idx_q       <= idx_q + 4'h1;
                    off_q       <= 8'h00;
                    state_q     <= ESS_RD;
                end
                ESS_RD:
                    state_q <= ESS_WR;
                ESS_WR:
                begin
                    off_q <= off_q + 8'h01;
                    if (off_q == cnt_q)
                        state_q <= ESS_CSUM;
                    else
                        state_q <= ESS_RD;
                end
                ESS_CSUM:
                    state_q <= ESS_FETCH;
                default:
                    state_q <= ESS_IDLE;
            endcase
        end
    end

    // Register-map address for the next byte of the block.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            map_addr <= 16'h0000;
        else if (state_q == ESS_RD)
            map_addr <= base_q + {8'h00, off_q};
    end

    // Running checksum over the copied bytes of one block.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sum_q <= 8'h00;
        else if (state_q == ESS_ADDR_LO)
            sum_q <= 8'h00;
        else if (state_q == ESS_WR)
            sum_q <= sum_q + map_rdata;
    end

    // EEPROM write strobe, address and data, one byte per strobe.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ee_wr    <= 1'b0;
            ee_addr  <= {EE_AW{1'b0}};
            ee_wdata <= 8'h00;
        end
        else
        begin
            ee_wr   <= 1'b0;
            ee_addr <= ptr_q;
            case (state_q)
                ESS_FETCH:
                begin
                    if (idx_q < ESS_SEQ_LEN && (cur == ESS_OP_IO_UPDATE
                        || (!cur[ESS_OP_KIND_BIT] && idx_q + 4'h2 < ESS_SEQ_LEN)))
                    begin
                        ee_wr    <= 1'b1;
                        ee_wdata <= cur;
                    end
                end
                ESS_ADDR_HI, ESS_ADDR_LO:
                begin
                    ee_wr    <= 1'b1;
                    ee_wdata <= cur;
                end
                ESS_WR:
                begin
                    ee_wr    <= 1'b1;
                    ee_wdata <= map_rdata;
                end
                ESS_CSUM:
                begin
                    // Stored so that the block plus its checksum adds up to zero.
                    ee_wr    <= 1'b1;
                    ee_wdata <= 8'h00 - sum_q;
                end
                default:
                    ee_wr <= 1'b0;
            endcase
        end
    end

    // Helper count of copied bytes in the current block, read only by the checks below.
    logic [8:0] blk_n_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            blk_n_q <= 9'h000;
        else if (state_q == ESS_ADDR_LO)
            blk_n_q <= 9'h000;
        else if (state_q == ESS_WR)
            blk_n_q <= blk_n_q + 9'h001;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // The address pair is fetched high then low, each stored in turn.
    sequence s_addr_pair;
        (state_q == ESS_ADDR_HI) ##1 (state_q == ESS_ADDR_LO);
    endsequence

    sequence s_two_stores;
        ee_wr ##1 ee_wr;
    endsequence

    AST_DATA_INSTR: assert property (
        (state_q == ESS_FETCH && idx_q + 4'h2 < ESS_SEQ_LEN && !cur[ESS_OP_KIND_BIT])
        |=> (state_q == ESS_ADDR_HI && cnt_q == $past(cur)))
        else $error("Data instruction not decoded.");

    AST_ADDR_HIGH_FIRST: assert property (
        s_addr_pair |=> (base_q[15:8] == $past(cur, 2) && base_q[7:0] == $past(cur)))
        else $error("Start address bytes in wrong order.");

    AST_ADDR_AFTER_INSTR: assert property (
        (state_q == ESS_ADDR_HI) |-> ($past(state_q) == ESS_FETCH))
        else $error("Address decoded without a data instruction.");

    AST_INSTR_STORED: assert property (
        (state_q == ESS_FETCH && idx_q + 4'h2 < ESS_SEQ_LEN && !cur[ESS_OP_KIND_BIT])
        |=> (ee_wr && ee_wdata == $past(cur) && ptr_q == ee_addr + 1'b1))
        else $error("Instruction byte not stored.");

    AST_ADDR_STORED: assert property (
        (state_q == ESS_ADDR_HI) |=> s_two_stores)
        else $error("Address bytes not stored.");

    AST_BLOCK_LENGTH: assert property (
        (state_q == ESS_CSUM) |-> (blk_n_q == {1'b0, cnt_q} + 9'h001) ##1 (ee_wr && state_q == ESS_FETCH))
        else $error("Block length or checksum store wrong.");

    AST_REFIN_RESET: assert property (
        $rose(aresetn) |-> (seq_q[0] == 8'h07 && seq_q[1] == 8'h05 && seq_q[2] == 8'h00))
        else $error("Reference-input entry reset wrong.");

    AST_PROF01_RESET: assert property (
        $rose(aresetn) |-> (seq_q[3] == 8'h63 && seq_q[4] == 8'h06 && seq_q[5] == 8'h00))
        else $error("Profile 0/1 entry reset wrong.");

    AST_PROF23_RESET: assert property (
        $rose(aresetn) |-> (seq_q[6] == 8'h63 && seq_q[7] == 8'h06 && seq_q[8] == 8'h80))
        else $error("Profile 2/3 entry reset wrong.");

    AST_IO_UPDATE: assert property (
        (state_q == ESS_FETCH && idx_q < ESS_SEQ_LEN && cur == ESS_OP_IO_UPDATE)
        |=> (ee_wr && ee_wdata == ESS_OP_IO_UPDATE && state_q == ESS_FETCH && ptr_q == ee_addr + 1'b1))
        else $error("I/O update not stored.");

    AST_CHECKSUM: assert property (
        (state_q == ESS_CSUM) |=> (ee_wdata == 8'h00 - $past(sum_q)))
        else $error("Checksum byte wrong.");

endmodule // ess_sequencer

// >>> src/ess_pkg.sv
// Function
// - A sequence byte N with bit 7 clear means copy N+1 register-map bytes.
// - The two bytes after a data instruction form the start address, high byte first.
// - The data instruction byte is stored and the EEPROM pointer advances by one.
// - N+1 map bytes from the start address are stored, then one checksum byte.
// - Reference-input entry resets to instruction 0x07 at address 0x0500.
// - Profile 0/1 entry resets to instruction 0x63 at address 0x0600.
// - Profile 2/3 entry resets to instruction 0x63 at address 0x0680.
// - Sequence byte 0x80 is an I/O update: stored, pointer advances by one.
package ess_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [13:0] ESS_IDX_REFIN_INSTR  = 14'h0e1f;
    localparam logic [13:0] ESS_IDX_REFIN_HI     = 14'h0e20;
    localparam logic [13:0] ESS_IDX_REFIN_LO     = 14'h0e21;
    localparam logic [13:0] ESS_IDX_PROF01_INSTR = 14'h0e22;
    localparam logic [13:0] ESS_IDX_PROF01_HI    = 14'h0e23;
    localparam logic [13:0] ESS_IDX_PROF01_LO    = 14'h0e24;
    localparam logic [13:0] ESS_IDX_PROF23_INSTR = 14'h0e25;
    localparam logic [13:0] ESS_IDX_PROF23_HI    = 14'h0e26;
    localparam logic [13:0] ESS_IDX_PROF23_LO    = 14'h0e27;
    localparam logic [13:0] ESS_IDX_CTRL         = 14'h0e30;
    localparam logic [13:0] ESS_IDX_STATUS       = 14'h0e31;
    localparam logic [13:0] ESS_IDX_POINTER      = 14'h0e32;

    // Number of scratch-pad sequence bytes walked by the sequencer.
    localparam logic [3:0] ESS_SEQ_LEN = 4'h9;

    // Reset contents of the sequence bytes, slot 0 in the low byte.
    localparam logic [71:0] ESS_SEQ_RESET = {8'h80, 8'h06, 8'h63,
                                             8'h00, 8'h06, 8'h63,
                                             8'h00, 8'h05, 8'h07};

    // Instruction decoding.
    localparam logic [7:0] ESS_OP_IO_UPDATE = 8'h80;
    localparam int         ESS_OP_KIND_BIT  = 7;

    // Control and status fields.
    localparam int ESS_CTRL_START_BIT  = 0;
    localparam int ESS_STAT_BUSY_BIT   = 0;
    localparam int ESS_STAT_DONE_BIT   = 1;
    localparam int ESS_STAT_BAD_BIT    = 2;
    localparam logic [31:0] ESS_POINTER_RESET = 32'h0000_0000;

    // AXI response codes.
    localparam logic [1:0] ESS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ESS_RESP_SLVERR = 2'h2;

    // Sequencer states.
    typedef enum logic [2:0] {
        ESS_IDLE    = 3'b000,
        ESS_FETCH   = 3'b001,
        ESS_ADDR_HI = 3'b010,
        ESS_ADDR_LO = 3'b011,
        ESS_RD      = 3'b100,
        ESS_WR      = 3'b101,
        ESS_CSUM    = 3'b110
    } ess_state_t;

endpackage

// >>> testbench/ess_eeprom_model.sv
`timescale 1ns/100ps

// Far side of the sequencer: a register map that answers at once and a byte-wide EEPROM.
module ess_eeprom_model #(
    parameter int EE_AW = 10
) (
    // Clock.
    input  wire logic             aclk,
    // Register-map read port.
    input  wire logic [15:0]      map_addr,
    output logic      [7:0]       map_rdata,
    // EEPROM byte write port.
    input  wire logic [EE_AW-1:0] ee_addr,
    input  wire logic [7:0]       ee_wdata,
    input  wire logic             ee_wr
);
    logic [7:0] mem [2**EE_AW];
    int         n_wr = 0;

    // Map bytes follow their address, so a byte copied from the wrong place shows up.
    assign map_rdata = map_addr[7:0] ^ {map_addr[9:8], 6'h2d};

    // Cells never written stay unknown, so a missed store cannot match by luck.
    always @(posedge aclk)
    begin
        if (ee_wr === 1'b1)
        begin
            mem[ee_addr] <= ee_wdata;
            n_wr         <= n_wr + 1;
        end
    end
endmodule // ess_eeprom_model

// >>> testbench/eeprom_store_sequencer_bench.sv
`timescale 1ns/100ps

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("FAIL %s exp %h got %h", nm, e, g); end end

module eeprom_store_sequencer_bench;
    import ess_pkg::*;

    typedef struct packed {logic [15:0] a; logic [7:0] d; logic [1:0] r;} ess_row_t;

    // Reset value of each mapped register, then one unmapped place.
    localparam ess_row_t ROWS [13] = '{
        '{{ESS_IDX_REFIN_INSTR, 2'h0}, 8'h07, ESS_RESP_OKAY}, '{{ESS_IDX_REFIN_HI, 2'h0}, 8'h05, ESS_RESP_OKAY},
        '{{ESS_IDX_REFIN_LO, 2'h0}, 8'h00, ESS_RESP_OKAY}, '{{ESS_IDX_PROF01_INSTR, 2'h0}, 8'h63, ESS_RESP_OKAY},
        '{{ESS_IDX_PROF01_HI, 2'h0}, 8'h06, ESS_RESP_OKAY}, '{{ESS_IDX_PROF01_LO, 2'h0}, 8'h00, ESS_RESP_OKAY},
        '{{ESS_IDX_PROF23_INSTR, 2'h0}, 8'h63, ESS_RESP_OKAY}, '{{ESS_IDX_PROF23_HI, 2'h0}, 8'h06, ESS_RESP_OKAY},
        '{{ESS_IDX_PROF23_LO, 2'h0}, 8'h80, ESS_RESP_OKAY}, '{{ESS_IDX_CTRL, 2'h0}, 8'h00, ESS_RESP_OKAY},
        '{{ESS_IDX_STATUS, 2'h0}, 8'h00, ESS_RESP_OKAY}, '{{ESS_IDX_POINTER, 2'h0}, 8'h00, ESS_RESP_OKAY},
        '{16'h3a00, 8'h00, ESS_RESP_SLVERR}};

    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000, map_addr;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [7:0]  map_rdata, ee_wdata, seq_q [9], exp_q [$];
    logic [9:0]  ee_addr;
    logic        ee_wr;
    int          fails = 0, n_tests = 0, n0 = 0;

    ess_sequencer #(.EE_AW(10)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .map_addr, .map_rdata, .ee_addr, .ee_wdata, .ee_wr);

    ess_eeprom_model #(.EE_AW(10)) u_mem (.aclk, .map_addr, .map_rdata, .ee_addr, .ee_wdata, .ee_wr);

    // 40 MHz clock.
    initial
    begin
        forever #12.5 aclk = ~aclk;
    end

    function automatic logic [15:0] reg_a(input logic [13:0] idx);
        return {idx, 2'b00};
    endfunction

    function automatic logic [7:0] map_byte(input logic [15:0] a);
        return a[7:0] ^ {a[9:8], 6'h2d};
    endfunction

    // Address and data go out together; each is dropped on its own ready, bready stays up until bvalid.
    task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        int   k;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 100 && !(aw_ok && w_ok); k++)
        begin
            @(posedge aclk);
            aw_ok = aw_ok || s_axi_awready === 1'b1;
            w_ok = w_ok || s_axi_wready === 1'b1;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        for (k = 0; k < 100 && s_axi_bvalid !== 1'b1; k++)
            @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        // The address is held up to the edge that samples arready high, or dropped after 100 edges without it.
        for (k = 0; k < 100; k++)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                break;
        end
        s_axi_arvalid <= 1'b0;
        for (k = 0; k < 100 && s_axi_rvalid !== 1'b1; k++)
            @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
        axi_read(a, rd, rs);
        `CHK("read data", {24'h0, d}, rd)
        `CHK("read resp", r, rs)
    endtask

    task automatic start_save();
        n0 = u_mem.n_wr;
        axi_write(reg_a(ESS_IDX_CTRL), 32'h1, rs);
    endtask

    // Polls status until the walk reports done or bad; the limit of 400 reads covers a walk that never ends.
    task automatic wait_end();
        int k;
        for (k = 0; k < 400; k++)
        begin
            axi_read(reg_a(ESS_IDX_STATUS), rd, rs);
            if (rd[ESS_STAT_DONE_BIT] === 1'b1 || rd[ESS_STAT_BAD_BIT] === 1'b1)
                break;
        end
    endtask

    // Walks seq_q the way the EEPROM image should come out and compares it with what was stored.
    task automatic check_save(input logic [9:0] p0);
        int          i;
        int          k;
        logic [15:0] a;
        logic [7:0]  sum;
        exp_q.delete();
        i = 0;
        while (i < 9)
        begin
            exp_q.push_back(seq_q[i]);
            if (seq_q[i] == ESS_OP_IO_UPDATE)
                i = i + 1;
            else
            begin
                a = {seq_q[i+1], seq_q[i+2]};
                exp_q.push_back(seq_q[i+1]);
                exp_q.push_back(seq_q[i+2]);
                sum = 8'h00;
                for (k = 0; k <= seq_q[i]; k++)
                begin
                    exp_q.push_back(map_byte(a + k[15:0]));
                    sum = sum + map_byte(a + k[15:0]);
                end
                exp_q.push_back(8'h00 - sum);
                i = i + 3;
            end
        end
        `CHK("store count", exp_q.size(), u_mem.n_wr - n0)
        for (k = 0; k < exp_q.size(); k++)
            `CHK("stored byte", exp_q[k], u_mem.mem[p0 + k[9:0]])
        axi_read(reg_a(ESS_IDX_POINTER), rd, rs);
        `CHK("pointer", 10'(p0 + exp_q.size()), rd[9:0])
    endtask

    task automatic row_loop();
        for (int i = 0; i < 13; i++)
            rd_chk(ROWS[i].a, ROWS[i].d, ROWS[i].r);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // The whole run needs under a thousand cycles; this limit is more than thirty times that.
    initial
    begin
        repeat (30000) @(posedge aclk);
        fails++;
        close_out();
    end

    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        row_loop();
        $display("test reset_values done");
        // Default list from pointer zero; a slot write while busy must be dropped.
        for (int i = 0; i < 9; i++)
            seq_q[i] = ESS_SEQ_RESET[8*i +: 8];
        start_save();
        axi_write(reg_a(ESS_IDX_REFIN_INSTR), 32'h11, rs);
        wait_end();
        check_save(10'h000);
        rd_chk(reg_a(ESS_IDX_REFIN_INSTR), 8'h07, ESS_RESP_OKAY);
        rd_chk(reg_a(ESS_IDX_STATUS), 8'h02, ESS_RESP_OKAY);
        axi_write(reg_a(ESS_IDX_STATUS), 32'h6, rs);
        rd_chk(reg_a(ESS_IDX_STATUS), 8'h00, ESS_RESP_OKAY);
        $display("test default_save done");
        // Update first, a one-byte block, a three-byte block, then an update in each of the last two slots.
        seq_q = '{8'h80, 8'h00, 8'h12, 8'h34, 8'h02, 8'hab, 8'hff, 8'h80, 8'h80};
        for (int i = 0; i < 9; i++)
            axi_write(reg_a(14'(ESS_IDX_REFIN_INSTR + i)), {24'h0, seq_q[i]}, rs);
        axi_write(reg_a(ESS_IDX_POINTER), 32'h100, rs);
        axi_write(16'h3a00, 32'h1, rs);
        `CHK("unmapped bresp", ESS_RESP_SLVERR, rs)
        start_save();
        wait_end();
        check_save(10'h100);
        axi_write(reg_a(ESS_IDX_STATUS), 32'h6, rs);
        $display("test custom_list done");
        // A byte with bit 7 set that is not the update code stops the walk.
        axi_write(reg_a(ESS_IDX_REFIN_INSTR), 32'h81, rs);
        start_save();
        wait_end();
        `CHK("bad flag", 1'b1, rd[ESS_STAT_BAD_BIT])
        // A data instruction in the last slot has no room for its address, so the walk stops at that slot with bad set.
        axi_write(reg_a(ESS_IDX_STATUS), 32'h6, rs);
        axi_write(reg_a(ESS_IDX_REFIN_INSTR), 32'h80, rs);
        axi_write(reg_a(ESS_IDX_PROF23_LO), 32'h05, rs);
        start_save();
        wait_end();
        `CHK("bad flag", 1'b1, rd[ESS_STAT_BAD_BIT])
        `CHK("done flag", 1'b0, rd[ESS_STAT_DONE_BIT])
        $display("test bad_instruction done");
        // Reset in the middle of a save brings every register back.
        axi_write(reg_a(ESS_IDX_REFIN_INSTR), 32'h07, rs);
        axi_write(reg_a(ESS_IDX_PROF01_INSTR), 32'h22, rs);
        start_save();
        repeat (5) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        `CHK("ee_wr in reset", 1'b0, ee_wr)
        aresetn <= 1'b1;
        @(posedge aclk);
        row_loop();
        $display("test mid_reset done");
        close_out();
    end
endmodule // eeprom_store_sequencer_bench
